// ### bench/qes_status_assertions.sv
`timescale 1ns/100ps
// watches bus timing and the interrupt output of the status block
module qes_status_chk (
    input wire        I_CLK,
    input wire        I_RST_N,
    input wire        HSEL,
    input wire [31:0] HADDR,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire [31:0] HWDATA,
    input wire        HREADY,
    input wire        HREADYOUT,
    input wire        HRESP,
    input wire        i_pos_overflow,
    input wire        i_vel_overflow,
    input wire        i_home_pin,
    input wire        i_index_pin,
    input wire        o_irq
);
    reg        wr_q;
    reg [15:0] en_q;
    wire       take = HSEL && HTRANS[1] && HREADY;

    // shadow of enable bits written to the status word
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wr_q <= 1'b0;
            en_q <= 16'h0000;
        end else if (HREADY) begin
            wr_q <= take && HWRITE && HADDR[7:0] == 8'h00;
            if (wr_q)
                en_q <= HWDATA[15:0] & 16'h1555;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    chk_bus_okay: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (
        take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    chk_irq_masked: assert property (
        en_q == 16'h0000 |-> !o_irq) else $error("irq while masked");
    chk_posov_irq: assert property (
        en_q[8] && i_pos_overflow |=> o_irq) else $error("posov no irq");
    chk_velov_irq: assert property (
        en_q[4] && i_vel_overflow |=> o_irq) else $error("velov no irq");
    chk_home_irq: assert property (
        $rose(i_home_pin) && en_q[2] |-> ##[1:6] o_irq)
        else $error("home no irq");
    chk_index_irq: assert property (
        $rose(i_index_pin) && en_q[0] |-> ##[1:6] o_irq)
        else $error("index no irq");
    chk_reset_quiet: assert property (
        $rose(I_RST_N) |-> !o_irq && HREADYOUT)
        else $error("not idle after reset");
endmodule // qes_status_chk

bind qes_status qes_status_chk qes_status_chk_i (.I_CLK, .I_RST_N, .HSEL,
    .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT, .HRESP,
    .i_pos_overflow, .i_vel_overflow, .i_home_pin, .i_index_pin, .o_irq);

// ### bench/qes_status_bench.sv
`timescale 1ns/100ps
// drives the status block over the bus and checks flags and interrupt
module qes_status_bench;
    reg         I_CLK   = 1'b0;
    reg         I_RST_N = 1'b0;
    reg  [31:0] HADDR   = 32'h0000_0000;
    reg  [1:0]  HTRANS  = 2'b00;
    reg         HWRITE  = 1'b0;
    reg  [31:0] HWDATA  = 32'h0000_0000;
    reg  [31:0] pos     = 32'h0000_0032;
    reg  [4:0]  src     = 5'b00000; // posov, velov, homing, home, index
    wire [31:0] HRDATA;
    wire        HREADYOUT;
    wire        HRESP;
    wire        o_irq;
    reg  [31:0] rd;
    integer     fails = 0;
    integer     samples_checked = 0;
    integer     k;

    always #50 I_CLK = ~I_CLK;

    qes_status qes_status_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .HSEL(1'b1),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .i_pos_count(pos),
        .i_pos_overflow(src[4]), .i_vel_overflow(src[3]),
        .i_homing_done(src[2]), .i_home_pin(src[1]), .i_index_pin(src[0]),
        .o_irq(o_irq));

    // flag position of each event source
    function [31:0] fbit(input integer n);
        case (n)
            0: fbit = 32'h0000_0200;
            1: fbit = 32'h0000_0020;
            2: fbit = 32'h0000_0080;
            3: fbit = 32'h0000_0008;
            default: fbit = 32'h0000_0002;
        endcase
    endfunction

    // one single transfer; read data lands in rd
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            HTRANS <= 2'b10;
            HWRITE <= w;
            HADDR <= {24'h00_0000, a};
            @(posedge I_CLK);
            while (HREADYOUT !== 1'b1) @(posedge I_CLK);
            HTRANS <= 2'b00;
            HWDATA <= d;
            @(posedge I_CLK);
            while (HREADYOUT !== 1'b1) @(posedge I_CLK);
            rd = HRDATA;
        end
    endtask

    task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk("rdata", e, rd);
        end
    endtask

    // pulse one event source, then let it settle
    task fire(input integer n);
        begin
            src[4-n] <= 1'b1;
            repeat (2) @(posedge I_CLK);
            src <= 5'b00000;
            repeat (6) @(posedge I_CLK);
        end
    endtask

    task t_compare;
        begin
            pos <= 32'h0000_0000;
            bus(1'b1, 8'h08, 32'h0000_0064);
            bus(1'b1, 8'h0C, 32'hFFFF_FF9C);
            bus(1'b1, 8'h04, 32'h0000_2AAA);
            rdchk(8'h00, 32'h0000_0000);
            pos <= 32'h0000_0064;
            repeat (2) @(posedge I_CLK);
            rdchk(8'h00, 32'h0000_2000);
            // clear while the condition holds: the set wins
            bus(1'b1, 8'h04, 32'h0000_2000);
            rdchk(8'h00, 32'h0000_2000);
            rdchk(8'h08, 32'h0000_0064);
            rdchk(8'h0C, 32'hFFFF_FF9C);
            rdchk(8'h14, 32'h0000_0064);
            pos <= 32'hFFFF_FF9C;
            repeat (2) @(posedge I_CLK);
            rdchk(8'h00, 32'h0000_2800);
            bus(1'b1, 8'h04, 32'h0000_2000);
            rdchk(8'h00, 32'h0000_0800);
            pos <= 32'h0000_0063;
            repeat (2) @(posedge I_CLK);
            bus(1'b1, 8'h04, 32'h0000_0800);
            rdchk(8'h00, 32'h0000_0000);
            pos <= 32'h0000_0000;
        end
    endtask

    task t_events;
        begin
            bus(1'b1, 8'h10, 32'h0000_0003);
            for (k = 0; k < 5; k = k + 1) begin
                fire(k);
                rdchk(8'h00, fbit(k));
                chk("irq", 32'h0000_0000, {31'h0, o_irq});
                bus(1'b1, 8'h00, 32'hFFFF_FFFF);
                rdchk(8'h00, fbit(k) | 32'h0000_1555);
                chk("irq", 32'h0000_0001, {31'h0, o_irq});
                bus(1'b1, 8'h04, fbit(k));
                // the clear lands on the edge the bus task returns on
                @(posedge I_CLK);
                chk("irq", 32'h0000_0000, {31'h0, o_irq});
                fire(k);
                chk("irq", 32'h0000_0001, {31'h0, o_irq});
                bus(1'b1, 8'h04, fbit(k));
                bus(1'b1, 8'h00, 32'h0000_0000);
            end
        end
    endtask

    // homing flag only in init modes 3 and 4
    task t_modes;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                bus(1'b1, 8'h10, k);
                rdchk(8'h10, k);
                fire(2);
                rdchk(8'h00, (k == 3 || k == 4) ? 32'h80 : 32'h0);
                bus(1'b1, 8'h04, 32'h0000_0080);
            end
        end
    endtask

    // state right after reset: only the upper flag, mode zero
    task t_reset;
        begin
            rdchk(8'h00, 32'h0000_2000);
            rdchk(8'h10, 32'h0000_0000);
        end
    endtask

    // unmapped and write-only offsets read zero
    task t_unmapped;
        begin
            rdchk(8'h40, 32'h0000_0000);
            bus(1'b1, 8'h40, 32'hFFFF_FFFF);
            rdchk(8'h04, 32'h0000_0000);
            rdchk(8'h00, 32'h0000_0000);
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_CLK);
        t_reset;
        t_compare;
        t_events;
        t_modes;
        t_unmapped;
        finish_test;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge I_CLK);
        fails = fails + 1;
        finish_test;
    end
endmodule // qes_status_bench

// ### common/qes_regs.vh
`ifndef QES_REGS_VH
`define QES_REGS_VH

// register byte offsets
`define QES_OFS_STATUS      8'h00
`define QES_OFS_CLEAR       8'h04
`define QES_OFS_UPPER_CMP   8'h08
`define QES_OFS_LOWER_CMP   8'h0C
`define QES_OFS_INIT_MODE   8'h10
`define QES_OFS_POS_COUNT   8'h14

// status word field positions
`define QES_BIT_UPPER_FLAG  13
`define QES_BIT_UPPER_EN    12
`define QES_BIT_LOWER_FLAG  11
`define QES_BIT_LOWER_EN    10
`define QES_BIT_POSOV_FLAG  9
`define QES_BIT_POSOV_EN    8
`define QES_BIT_HOMING_FLAG 7
`define QES_BIT_HOMING_EN   6
`define QES_BIT_VELOV_FLAG  5
`define QES_BIT_VELOV_EN    4
`define QES_BIT_HOME_FLAG   3
`define QES_BIT_HOME_EN     2
`define QES_BIT_INDEX_FLAG  1
`define QES_BIT_INDEX_EN    0

// widths
`define QES_STATUS_W        16
`define QES_NUM_EVENTS      7
`define QES_POS_W           32
`define QES_MODE_W          3

// reset values
`define QES_RST_STATUS      16'h0000
`define QES_RST_CMP         32'h0000_0000
`define QES_RST_MODE        3'h0

// init-mode codes for which the homing flag is meaningful
`define QES_MODE_HOME_A     3'h3
`define QES_MODE_HOME_B     3'h4

`endif

// ### design/qes_flag.v
`timescale 1ns/100ps
// one sticky, hardware-set event flag; a set beats a same-cycle clear
module qes_flag (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_set,
    input  wire i_clr,
    output wire o_flag
);

    reg flag_q;

    // sticky storage, set priority over clear
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_q <= 1'b0;
        end else if (i_set) begin
            flag_q <= 1'b1;
        end else if (i_clr) begin
            flag_q <= 1'b0;
        end
    end

    assign o_flag = flag_q;

endmodule // qes_flag

// ### design/qes_status.v
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "qes_regs.vh"
module qes_status (
    input  wire        I_CLK,
    input  wire        I_RST_N,
    // ahb-lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    // counters on the same clock
    input  wire [31:0] i_pos_count,
    input  wire        i_pos_overflow,
    input  wire        i_vel_overflow,
    input  wire        i_homing_done,
    // pins from outside the clock domain
    input  wire        i_home_pin,
    input  wire        i_index_pin,
    // interrupt request
    output wire        o_irq
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_RWAIT = 3'b010;
    localparam ST_RDATA = 3'b100;

    reg  [2:0]                  state_q;
    reg  [2:0]                  state_d;
    reg  [7:0]                  addr_q;
    reg                         wr_pend_q;
    reg  [31:0]                 rdata_q;
    reg  [`QES_POS_W-1:0]       upper_cmp_q;
    reg  [`QES_POS_W-1:0]       lower_cmp_q;
    reg  [`QES_MODE_W-1:0]      init_mode_q;
    reg  [`QES_NUM_EVENTS-1:0]  enable_q;
    reg  [2:0]                  home_sync_q;
    reg  [2:0]                  index_sync_q;
    reg                         home_level_q;
    reg                         index_level_q;
    reg  [31:0]                 rd_word;
    wire                        addr_phase;
    wire                        wr_status;
    wire                        wr_clear;
    wire [`QES_NUM_EVENTS-1:0]  ev_set;
    wire [`QES_NUM_EVENTS-1:0]  ev_clr;
    wire [`QES_NUM_EVENTS-1:0]  flags;
    wire [`QES_STATUS_W-1:0]    status_word;
    wire                        homing_mode_ok;
    wire                        home_edge;
    wire                        index_edge;
    wire                        upper_hit;
    wire                        lower_hit;
    genvar                      g;

    // a transfer addressed to this slave
    assign addr_phase = HSEL & HTRANS[1] & HREADY;

    // bus handshake: reads take one wait state, writes none
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (addr_phase && !HWRITE) begin
                    state_d = ST_RWAIT;
                end
            end
            ST_RWAIT: begin
                state_d = ST_RDATA;
            end
            ST_RDATA: begin
                if (addr_phase && !HWRITE) begin
                    state_d = ST_RWAIT;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state, latched address and write pending flag
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q   <= ST_IDLE;
            addr_q    <= 8'h00;
            wr_pend_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            wr_pend_q <= addr_phase & HWRITE;
            if (addr_phase) begin
                addr_q <= HADDR[7:0];
            end
        end
    end

    assign HREADYOUT = (state_q != ST_RWAIT);
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_q;

    // write strobes in the data phase
    assign wr_status = wr_pend_q & (addr_q == `QES_OFS_STATUS);
    assign wr_clear  = wr_pend_q & (addr_q == `QES_OFS_CLEAR);

    // software-written control registers
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            upper_cmp_q <= `QES_RST_CMP;
            lower_cmp_q <= `QES_RST_CMP;
            init_mode_q <= `QES_RST_MODE;
            enable_q    <= {`QES_NUM_EVENTS{1'b0}};
        end else if (wr_pend_q) begin
            if (addr_q == `QES_OFS_UPPER_CMP) begin
                upper_cmp_q <= HWDATA;
            end
            if (addr_q == `QES_OFS_LOWER_CMP) begin
                lower_cmp_q <= HWDATA;
            end
            if (addr_q == `QES_OFS_INIT_MODE) begin
                init_mode_q <= HWDATA[`QES_MODE_W-1:0];
            end
            if (wr_status) begin
                // enables are plain storage; flag bits ignore writes
                enable_q <= {HWDATA[`QES_BIT_UPPER_EN],
                             HWDATA[`QES_BIT_LOWER_EN],
                             HWDATA[`QES_BIT_POSOV_EN],
                             HWDATA[`QES_BIT_HOMING_EN],
                             HWDATA[`QES_BIT_VELOV_EN],
                             HWDATA[`QES_BIT_HOME_EN],
                             HWDATA[`QES_BIT_INDEX_EN]};
            end
        end
    end

    // pin synchronisers: change counted once stages two and three agree
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            home_sync_q   <= 3'b000;
            index_sync_q  <= 3'b000;
            home_level_q  <= 1'b0;
            index_level_q <= 1'b0;
        end else begin
            home_sync_q  <= {home_sync_q[1:0], i_home_pin};
            index_sync_q <= {index_sync_q[1:0], i_index_pin};
            if (home_sync_q[1] == home_sync_q[2]) begin
                home_level_q <= home_sync_q[2];
            end
            if (index_sync_q[1] == index_sync_q[2]) begin
                index_level_q <= index_sync_q[2];
            end
        end
    end

    // rising edge of the filtered pin levels
    assign home_edge  = home_sync_q[1] & home_sync_q[2] & ~home_level_q;
    assign index_edge = index_sync_q[1] & index_sync_q[2] & ~index_level_q;

    // signed position compares, evaluated every cycle
    assign upper_hit = ($signed(i_pos_count) >= $signed(upper_cmp_q));
    assign lower_hit = ($signed(i_pos_count) <= $signed(lower_cmp_q));

    // homing reinit only counts in the two homing init modes
    assign homing_mode_ok = (init_mode_q == `QES_MODE_HOME_A) |
                            (init_mode_q == `QES_MODE_HOME_B);

    // event sources, msb = upper compare down to lsb = index
    assign ev_set[6] = upper_hit;
    assign ev_set[5] = lower_hit;
    assign ev_set[4] = i_pos_overflow;
    assign ev_set[3] = i_homing_done & homing_mode_ok;
    assign ev_set[2] = i_vel_overflow;
    assign ev_set[1] = home_edge;
    assign ev_set[0] = index_edge;

    // write-one-to-clear strobes in flag positions
    assign ev_clr = {HWDATA[`QES_BIT_UPPER_FLAG],
                     HWDATA[`QES_BIT_LOWER_FLAG],
                     HWDATA[`QES_BIT_POSOV_FLAG],
                     HWDATA[`QES_BIT_HOMING_FLAG],
                     HWDATA[`QES_BIT_VELOV_FLAG],
                     HWDATA[`QES_BIT_HOME_FLAG],
                     HWDATA[`QES_BIT_INDEX_FLAG]} &
                    {`QES_NUM_EVENTS{wr_clear}};

    // one sticky cell per event
    generate
        for (g = 0; g < `QES_NUM_EVENTS; g = g + 1) begin : g_flag
            qes_flag u_flag (
                .i_clk   (I_CLK),
                .i_rst_n (I_RST_N),
                .i_set   (ev_set[g]),
                .i_clr   (ev_clr[g]),
                .o_flag  (flags[g])
            );
        end
    endgenerate

    // status word: flag above its enable, top two bits zero
    assign status_word = {2'b00,
                          flags[6], enable_q[6],
                          flags[5], enable_q[5],
                          flags[4], enable_q[4],
                          flags[3], enable_q[3],
                          flags[2], enable_q[2],
                          flags[1], enable_q[1],
                          flags[0], enable_q[0]};

    // interrupt: any flag with its enable
    assign o_irq = |(flags & enable_q);

    // read mux; unmapped and clear register read zero
    always @* begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            `QES_OFS_STATUS: begin
                rd_word = {16'h0000, status_word};
            end
            `QES_OFS_UPPER_CMP: begin
                rd_word = upper_cmp_q;
            end
            `QES_OFS_LOWER_CMP: begin
                rd_word = lower_cmp_q;
            end
            `QES_OFS_INIT_MODE: begin
                rd_word = {29'h0000_0000, init_mode_q};
            end
            `QES_OFS_POS_COUNT: begin
                rd_word = i_pos_count;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // read data captured in the wait cycle, after any prior write landed
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (state_q == ST_RWAIT) begin
            rdata_q <= rd_word;
        end
    end

endmodule // qes_status
